// >>> hw/twd_core.sv
`include "twd_cfg.svh"
module twd_core import twd_pkg::*; #(
    parameter int unsigned WDT_CYCLES = `TWD_WDT_TIMEOUT_US * `TWD_MCLK_MHZ
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [11:0] PROG_DATA,
    input wire logic [5:0] PB_IN,
    input wire logic MASTER_CLEAR_PIN_N,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_WR,
    output logic [10:0] PROG_ADDR,
    output logic [5:0] PB_OUT,
    output logic [5:0] PB_OE_N,
    output logic OSC_RUN,
    output logic WB_ACK,
    output logic [31:0] WB_DAT_RD
);
    localparam twd_regs_t RST = '{st: TWD_RUN, osc: 1'b1, pc: `TWD_PC_RESET, flush: 1'b1,
        status: `TWD_STATUS_POR, option: `TWD_OPTION_RESET, load_direction_op: 6'h3F,
        ctrl: `TWD_CTRL_RESET, default: '0};
    localparam logic [19:0] WDT_LAST = 20'(WDT_CYCLES - 1);
    twd_regs_t s;
    twd_regs_t n;
    // --------------------------------------------------------------
    // instruction fields
    // --------------------------------------------------------------
    logic [4:0] fa;
    logic [3:0] bop;
    logic [3:0] lop;
    logic d;
    logic [2:0] bsel;
    logic [7:0] k;
    logic [7:0] src;
    logic [7:0] addend;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic is_sub;
    logic running;
    logic exec;
    logic wdt_to, master_clear_pin_ev, pin_ev, ev_rst;
    logic [7:0] res;
    logic [7:0] mask;
    logic wr_w, wr_f;
    logic fz, fc, fdc;
    logic cnew, dcnew;
    logic touch_pb;

    // word split into opcode and operand fields
    assign fa = s.ir[4:0];
    assign bop = s.ir[9:6];
    assign lop = s.ir[11:8];
    assign d = s.ir[5];
    assign bsel = s.ir[7:5];
    assign k = s.ir[7:0];
    // port reads see the pins, so read-modify-write never echoes the latch
    assign src = (fa == `TWD_F_PORT_B_REGISTER) ? {2'h0, PB_IN} :
                 (fa == `TWD_F_PCL) ? s.pc[7:0] :
                 (fa == `TWD_F_STATUS) ? s.status : s.files[fa];
    // one adder serves add and subtract; subtract is f plus inverted w plus one
    assign is_sub = (s.ir[11:10] == 2'h0) && (bop == `TWD_OP_SUB);
    assign addend = is_sub ? ~s.w : s.w;
    assign sum9 = {1'b0, src} + {1'b0, addend} + {8'h00, is_sub};
    assign nib5 = {1'b0, src[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
    // wake and reset sources
    assign wdt_to = s.ctrl[`TWD_CTRL_WDT_EN] && (s.wdt == WDT_LAST);
    assign master_clear_pin_ev = s.ctrl[`TWD_CTRL_MASTER_CLEAR_PIN_EN] && !MASTER_CLEAR_PIN_N;
    assign pin_ev = (s.st == TWD_SLEEP) && !s.option[`TWD_OPT_WAKE_N] &&
                    (((PB_IN ^ s.pb_last) & `TWD_WAKE_MASK) != 6'h00);
    assign ev_rst = master_clear_pin_ev || wdt_to || pin_ev;
    assign running = s.ctrl[`TWD_CTRL_RUN] && (s.st == TWD_RUN);
    assign exec = running && (s.ph == `TWD_PH_LAST) && !s.flush && !ev_rst;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        n = s;
        res = 8'h00;
        mask = 8'h01 << bsel;
        wr_w = 1'b0;
        wr_f = 1'b0;
        fz = 1'b0;
        fc = 1'b0;
        fdc = 1'b0;
        cnew = sum9[8];
        dcnew = nib5[4];
        touch_pb = 1'b0;
        // bus slave: ack one cycle, then drop
        n.ack = WB_CYC && WB_STB && !s.ack;
        n.rdat = 32'h0000_0000;
        if (n.ack) begin
            if (WB_ADR == `TWD_ADR_CTRL) begin
                n.rdat = {29'h0, s.ctrl};
                if (WB_WE && WB_SEL[0]) begin
                    n.ctrl = WB_DAT_WR[2:0];
                end
            end else if (WB_ADR == `TWD_ADR_WORK) begin
                n.rdat = {24'h0, s.w};
            end else if (WB_ADR == `TWD_ADR_STATUS) begin
                n.rdat = {24'h0, s.status};
            end else if (WB_ADR == `TWD_ADR_PC) begin
                n.rdat = {21'h0, s.pc};
            end else if (WB_ADR == `TWD_ADR_OPTION) begin
                n.rdat = {24'h0, s.option};
            end
        end
        // watchdog keeps counting in power-down, that is how it wakes the core
        if (s.ctrl[`TWD_CTRL_WDT_EN]) begin
            n.wdt = s.wdt + 20'h00001;
        end
        // four clock periods per instruction cycle; fetch on the last one
        if (running) begin
            n.ph = s.ph + 2'h1;
            if (s.ph == `TWD_PH_LAST) begin
                n.ir = PROG_DATA;
                n.pc = s.pc + 11'h001;
                n.flush = 1'b0;
            end
        end
        if (exec) begin
            case (s.ir[11:10])
                2'h0: begin
                    touch_pb = (fa == `TWD_F_PORT_B_REGISTER);
                    case (bop)
                        `TWD_OP_MISC: begin
                            if (d) begin
                                res = s.w;
                                wr_f = 1'b1;
                            end else if (s.ir == `TWD_W_OPTION) begin
                                n.option = s.w;
                            end else if (s.ir == `TWD_W_SLEEP) begin
                                n.st = TWD_SLEEP;
                                n.osc = 1'b0;
                                n.wdt = 20'h00000;
                                n.status[`TWD_ST_TO] = 1'b1;
                                n.status[`TWD_ST_PD] = 1'b0;
                            end else if (s.ir == `TWD_W_KICK) begin
                                n.wdt = 20'h00000;
                                n.status[`TWD_ST_TO] = 1'b1;
                                n.status[`TWD_ST_PD] = 1'b1;
                            end else if (s.ir[11:3] == 9'h000 && s.ir[2:0] == `TWD_LOAD_DIRECTION_OP_SEL) begin
                                n.load_direction_op = s.w[5:0];
                            end
                            touch_pb = 1'b0;
                        end
                        `TWD_OP_CLR: begin
                            res = 8'h00;
                            wr_w = !d;
                            wr_f = d;
                            fz = 1'b1;
                        end
                        `TWD_OP_SUB, `TWD_OP_ADD: begin
                            res = sum9[7:0];
                            fz = 1'b1;
                            fc = 1'b1;
                            fdc = 1'b1;
                        end
                        `TWD_OP_DEC: begin
                            res = src - 8'h01;
                            fz = 1'b1;
                        end
                        `TWD_OP_INC: begin
                            res = src + 8'h01;
                            fz = 1'b1;
                        end
                        `TWD_OP_IOR: begin
                            res = src | s.w;
                            fz = 1'b1;
                        end
                        `TWD_OP_AND: begin
                            res = src & s.w;
                            fz = 1'b1;
                        end
                        `TWD_OP_XOR: begin
                            res = src ^ s.w;
                            fz = 1'b1;
                        end
                        `TWD_OP_MOV: begin
                            res = src;
                            fz = 1'b1;
                        end
                        `TWD_OP_COM: begin
                            res = ~src;
                            fz = 1'b1;
                        end
                        `TWD_OP_DECSZ, `TWD_OP_INCSZ: begin
                            res = (bop == `TWD_OP_DECSZ) ? src - 8'h01 : src + 8'h01;
                            n.flush = (res == 8'h00);
                        end
                        `TWD_OP_RRC: begin
                            res = {s.status[`TWD_ST_C], src[7:1]};
                            cnew = src[0];
                            fc = 1'b1;
                        end
                        `TWD_OP_RLC: begin
                            res = {src[6:0], s.status[`TWD_ST_C]};
                            cnew = src[7];
                            fc = 1'b1;
                        end
                        default: begin
                            res = {src[3:0], src[7:4]};
                        end
                    endcase
                    // destination select for everything but misc and clear
                    if (bop != `TWD_OP_MISC && bop != `TWD_OP_CLR) begin
                        wr_w = !d;
                        wr_f = d;
                    end
                end
                2'h1: begin
                    touch_pb = (fa == `TWD_F_PORT_B_REGISTER);
                    case (s.ir[9:8])
                        2'h0: begin
                            res = src & ~mask;
                            wr_f = 1'b1;
                        end
                        2'h1: begin
                            res = src | mask;
                            wr_f = 1'b1;
                        end
                        2'h2: n.flush = !src[bsel];
                        default: n.flush = src[bsel];
                    endcase
                end
                default: begin
                    if (lop == `TWD_LIT_RET) begin
                        n.w = k;
                        n.pc = s.stack[0];
                        n.stack[0] = s.stack[1];
                        n.flush = 1'b1;
                    end else if (lop == `TWD_LIT_CALL) begin
                        n.stack[1] = s.stack[0];
                        n.stack[0] = s.pc;
                        n.pc = {s.status[6:5], 1'b0, k};
                        n.flush = 1'b1;
                    end else if (s.ir[11:9] == 3'h5) begin
                        n.pc = {s.status[6:5], s.ir[8:0]};
                        n.flush = 1'b1;
                    end else begin
                        // literal group, load leaves the zero flag alone
                        if (lop == `TWD_LIT_LOAD) begin
                            res = k;
                        end else if (lop == `TWD_LIT_IOR) begin
                            res = s.w | k;
                        end else if (lop == `TWD_LIT_AND) begin
                            res = s.w & k;
                        end else begin
                            res = s.w ^ k;
                        end
                        fz = (lop != `TWD_LIT_LOAD);
                        wr_w = 1'b1;
                    end
                end
            endcase
            if (wr_w) begin
                n.w = res;
            end
            // file write; counter low byte write is a computed jump
            if (wr_f) begin
                if (fa == `TWD_F_PCL) begin
                    n.pc = {s.status[6:5], 1'b0, res};
                    n.flush = 1'b1;
                end else if (fa == `TWD_F_STATUS) begin
                    n.status[6:5] = res[6:5];
                    n.status[2:0] = res[2:0];
                end else if (fa == `TWD_F_PORT_B_REGISTER) begin
                    n.pb_lat = res[5:0];
                end else begin
                    n.files[fa] = res;
                end
            end
            // flag writes come after the file write, as the core would latch them
            if (fz) begin
                n.status[`TWD_ST_Z] = (res == 8'h00);
            end
            if (fc) begin
                n.status[`TWD_ST_C] = cnew;
            end
            if (fdc) begin
                n.status[`TWD_ST_DC] = dcnew;
            end
            // pin snapshot for change wake, taken on any port file op outside the misc group, or any port bit op
            if (touch_pb) begin
                n.pb_last = PB_IN;
            end
        end
        // device reset from a wake source; file contents and work survive
        if (ev_rst) begin
            n.st = TWD_RUN;
            n.osc = 1'b1;
            n.ph = 2'h0;
            n.pc = `TWD_PC_RESET;
            n.flush = 1'b1;
            n.wdt = 20'h00000;
            n.status[7:5] = 3'h0;
            if (master_clear_pin_ev) begin
                if (s.st == TWD_SLEEP) begin
                    n.status[`TWD_ST_TO] = 1'b1;
                    n.status[`TWD_ST_PD] = 1'b0;
                end
            end else if (wdt_to) begin
                n.status[`TWD_ST_TO] = 1'b0;
                if (s.st == TWD_SLEEP) begin
                    n.status[`TWD_ST_PD] = 1'b0;
                end
            end else begin
                n.status[`TWD_ST_WAKE] = 1'b1;
                n.status[`TWD_ST_TO] = 1'b1;
                n.status[`TWD_ST_PD] = 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    // outputs are plain fields of the state register
    assign PROG_ADDR = s.pc;
    assign PB_OUT = s.pb_lat;
    assign PB_OE_N = s.load_direction_op;
    assign OSC_RUN = s.osc;
    assign WB_ACK = s.ack;
    assign WB_DAT_RD = s.rdat;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    property p_phase;
        running && !ev_rst |=> s.ph == $past(s.ph) + 2'h1;
    endproperty
    a_phase: assert property (p_phase) else $error("phase did not advance");
    property p_skip;
        exec && s.ir[11:10] == 2'h0 && (bop == `TWD_OP_DECSZ || bop == `TWD_OP_INCSZ)
            && res == 8'h00 |=> s.flush;
    endproperty
    a_skip: assert property (p_skip) else $error("zero skip not taken");
    property p_call;
        exec && s.ir[11:8] == `TWD_LIT_CALL |=> s.pc[8] == 1'b0
            && s.pc[7:0] == $past(k) && s.stack[0] == $past(s.pc) && s.flush;
    endproperty
    a_call: assert property (p_call) else $error("call target wrong");
    property p_jump;
        exec && s.ir[11:9] == 3'h5 |=> s.pc[8:0] == $past(s.ir[8:0]) && s.flush
            ##4 !s.flush;
    endproperty
    a_jump: assert property (p_jump) else $error("jump wrong");
    property p_sleep;
        exec && s.ir == `TWD_W_SLEEP |=> s.st == TWD_SLEEP && s.status[`TWD_ST_TO]
            && !s.status[`TWD_ST_PD] && !OSC_RUN && s.wdt == 20'h00000;
    endproperty
    a_sleep: assert property (p_sleep) else $error("power-down entry wrong");
    property p_hold;
        s.st == TWD_SLEEP && $past(s.st == TWD_SLEEP) |-> $stable(PB_OUT) && $stable(PB_OE_N);
    endproperty
    a_hold: assert property (p_hold) else $error("port moved in power-down");
    property p_dir;
        exec && s.ir == {9'h000, `TWD_LOAD_DIRECTION_OP_SEL} |=> PB_OE_N == $past(s.w[5:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction load wrong");
    property p_dest;
        exec && s.ir[11:10] == 2'h0 && wr_w && !d |=> s.w == $past(res);
    endproperty
    a_dest: assert property (p_dest) else $error("work destination wrong");
    property p_wdt_wake;
        wdt_to && !master_clear_pin_ev && s.st == TWD_SLEEP |=> s.st == TWD_RUN
            && PROG_ADDR == `TWD_PC_RESET && !s.status[`TWD_ST_TO] && s.wdt == 20'h00000;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");
    property p_ack;
        WB_ACK |=> !WB_ACK;
    endproperty
    a_ack: assert property (p_ack) else $error("ack longer than one cycle");
    c_sleep: cover property (exec && s.ir == `TWD_W_SLEEP);
    c_pin_wake: cover property (pin_ev && !master_clear_pin_ev && !wdt_to);
    c_call: cover property (exec && s.ir[11:8] == `TWD_LIT_CALL);
    c_skip: cover property (exec && s.ir[11:10] == 2'h1 && n.flush);
endmodule

// >>> common/twd_cfg.svh
`ifndef TWD_CFG_SVH
`define TWD_CFG_SVH
// Behaviour
// - every instruction is fetched and decoded as one 12-bit word
// - byte results go to the work register when d is 0, to the file when 1
// - file field picks one of 32 registers; bit field picks the bit
// - one cycle per instruction, two when a skip is taken or the counter changes
// - each instruction cycle is four clock periods
// - add work to file; carry, digit carry and zero updated
// - subtract work from file; carry, digit carry and zero updated
// - or, and, xor work with file; only zero flag updated
// - decrement and increment file into destination; only zero flag updated
// - decrement or increment with skip on zero result; no flags touched
// - rotate file left or right through carry; only carry touched
// - bit clear, bit set, skip if low, skip if high; no flags touched
// - and, or, xor literal into work updating zero; load literal leaves flags
// - call and return with literal take two cycles, flags unchanged
// - every counter write except jump and return forces counter bit 8 low
// - fixed words for idle, option load, power-down and watchdog kick
// - direction load with select 6 copies work into port-B direction latches
// - port read-modify-write uses sampled pin levels as source
// - power-down clears watchdog, sets time-out, clears power-down, holds ports
// - master clear, watchdog time-out or pin change wake with device reset
// - call pushes next address, loads literal, page bits, clears bit 8
`define TWD_MCLK_MHZ 25
`define TWD_WDT_TIMEOUT_US 18000
`define TWD_PH_LAST 2'h3
`define TWD_PC_RESET 11'h7FF
`define TWD_STATUS_POR 8'h18
`define TWD_OPTION_RESET 8'hFF
`define TWD_CTRL_RESET 3'h7
`define TWD_CTRL_RUN 0
`define TWD_CTRL_MASTER_CLEAR_PIN_EN 1
`define TWD_CTRL_WDT_EN 2
`define TWD_OPT_WAKE_N 7
`define TWD_ADR_CTRL 8'h00
`define TWD_ADR_WORK 8'h04
`define TWD_ADR_STATUS 8'h08
`define TWD_ADR_PC 8'h0C
`define TWD_ADR_OPTION 8'h10
`define TWD_F_PCL 5'h02
`define TWD_F_STATUS 5'h03
`define TWD_F_PORT_B_REGISTER 5'h06
`define TWD_ST_C 0
`define TWD_ST_DC 1
`define TWD_ST_Z 2
`define TWD_ST_PD 3
`define TWD_ST_TO 4
`define TWD_ST_WAKE 7
`define TWD_W_IDLE 12'h000
`define TWD_W_OPTION 12'h002
`define TWD_W_SLEEP 12'h003
`define TWD_W_KICK 12'h004
`define TWD_LOAD_DIRECTION_OP_SEL 3'h6
`define TWD_WAKE_MASK 6'h1B
`define TWD_OP_MISC 4'h0
`define TWD_OP_CLR 4'h1
`define TWD_OP_SUB 4'h2
`define TWD_OP_DEC 4'h3
`define TWD_OP_IOR 4'h4
`define TWD_OP_AND 4'h5
`define TWD_OP_XOR 4'h6
`define TWD_OP_ADD 4'h7
`define TWD_OP_MOV 4'h8
`define TWD_OP_COM 4'h9
`define TWD_OP_INC 4'hA
`define TWD_OP_DECSZ 4'hB
`define TWD_OP_RRC 4'hC
`define TWD_OP_RLC 4'hD
`define TWD_OP_SWAP 4'hE
`define TWD_OP_INCSZ 4'hF
`define TWD_LIT_RET 4'h8
`define TWD_LIT_CALL 4'h9
`define TWD_LIT_LOAD 4'hC
`define TWD_LIT_IOR 4'hD
`define TWD_LIT_AND 4'hE
`define TWD_LIT_XOR 4'hF
`endif

// >>> common/twd_pkg.sv
`include "twd_cfg.svh"
package twd_pkg;
    typedef enum logic {TWD_RUN = 1'b0, TWD_SLEEP = 1'b1} twd_state_t;
    typedef struct packed {
        twd_state_t st;
        logic osc;
        logic [1:0] ph;
        logic [10:0] pc;
        logic [11:0] ir;
        logic flush;
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] option;
        logic [5:0] load_direction_op;
        logic [5:0] pb_lat;
        logic [5:0] pb_last;
        logic [1:0][10:0] stack;
        logic [19:0] wdt;
        logic [31:0][7:0] files;
        logic [2:0] ctrl;
        logic ack;
        logic [31:0] rdat;
    } twd_regs_t;
endpackage

// >>> sim/twd_prog_mem.sv
module twd_prog_mem (
    input wire logic [10:0] addr,
    output logic [11:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // word store
    // ----------
    logic [11:0] words [0:2047];
    // answers at once, so a word is settled long before the fetch edge
    assign data = words[addr];
endmodule

// >>> sim/twd_core_tb_top.sv
module twd_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic master_clear_pin_n = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [5:0] pb_in = 6'h2A;
    logic [31:0] rd;
    logic [31:0] rdat;
    logic [11:0] pdata;
    logic [10:0] paddr;
    logic [5:0] pb_out;
    logic [5:0] pb_oe_n;
    logic osc_run;
    logic ack;
    logic [11:0] prog [$];
    int bad_count = 0;
    int checked = 0;

    // ---------------
    // clock and parts
    // ---------------
    always #20 mclk = ~mclk;

    twd_prog_mem mem (.addr(paddr), .data(pdata));

    // short watchdog span keeps the sleep wake within a few thousand cycles
    twd_core #(.WDT_CYCLES(1000)) uut (.MCLK(mclk), .NRST(nrst), .PROG_DATA(pdata),
        .PB_IN(pb_in), .MASTER_CLEAR_PIN_N(master_clear_pin_n), .WB_CYC(cyc), .WB_STB(stb),
        .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_WR(wdat), .PROG_ADDR(paddr),
        .PB_OUT(pb_out), .PB_OE_N(pb_oe_n), .OSC_RUN(osc_run), .WB_ACK(ack),
        .WB_DAT_RD(rdat));

    // compare, count, report at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic bus cycle, held until ack is seen
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'h1);
        rd = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        sel <= 4'h0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask

    // memory is loaded under reset so no fetch edge sees a half-written image
    task automatic run_prog(input logic [7:0] w_exp, input logic [7:0] st_exp);
        @(posedge mclk);
        nrst <= 1'h0;
        @(negedge mclk);
        foreach (mem.words[i]) mem.words[i] = 12'h000;
        foreach (prog[i]) mem.words[i] = prog[i];
        repeat (20) @(posedge mclk);
        nrst <= 1'h1;
        wait (paddr !== 11'h7FF);
        for (int n = 0; n < 5; n++) begin
            @(negedge mclk);
            chk(paddr, (n == 4) ? 32'h1 : 32'h0);
        end
        repeat (200) @(posedge mclk);
        rdchk(8'h04, {24'h0, w_exp});
        rdchk(8'h08, {24'h0, st_exp});
    endtask

    task automatic finish_test;
        $display("mismatches %0d, comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        bad_count++;
        finish_test;
    end

    initial begin
        prog = '{12'hC17, 12'h028, 12'hCC2, 12'h1C8, 12'h1E8, 12'h208, 12'hA06};
        run_prog(8'hF0, 8'h1A);
        prog = '{12'hC05, 12'h028, 12'h088, 12'hA03};
        run_prog(8'h00, 8'h1F);
        prog = '{12'hC3C, 12'h028, 12'hC0F, 12'h148, 12'h188, 12'h108, 12'hEF0, 12'hDC3,
            12'hFF3, 12'hA09};
        run_prog(8'h00, 8'h1C);
        prog = '{12'hC80, 12'h028, 12'h368, 12'h328, 12'h2A8, 12'h0E8, 12'h388, 12'h248,
            12'hA08};
        run_prog(8'h7F, 8'h18);
        prog = '{12'hC01, 12'h028, 12'h2E8, 12'hC55, 12'h528, 12'h728, 12'hCAA, 12'h628,
            12'hC33, 12'h068, 12'hA0A};
        run_prog(8'h33, 8'h1C);
        prog = '{12'h907, 12'h026, 12'hC12, 12'h006, 12'h2A6, 12'h206, 12'hA06, 12'h8A5};
        run_prog(8'h2A, 8'h18);
        chk(pb_out, 32'h2B);
        chk(pb_oe_n, 32'h12);
        // skip on increment, clear work, bit clear, then a kick loop that outlives the watchdog
        prog = '{12'hCFF, 12'h028, 12'h3E8, 12'hC55, 12'h040, 12'h3E8, 12'h408, 12'h228,
            12'h004, 12'hA08};
        run_prog(8'h00, 8'h1C);
        repeat (1100) @(posedge mclk);
        rdchk(8'h08, 32'h1C);
        // sleep with pin wake armed, then each wake source in turn
        prog = '{12'hC7F, 12'h026, 12'h002, 12'h206, 12'h003, 12'hA05};
        run_prog(8'h2A, 8'h10);
        chk(osc_run, 32'h0);
        chk(pb_out, 32'h3F);
        rdchk(8'h10, 32'h7F);
        rdchk(8'h20, 32'h0);
        @(posedge mclk);
        pb_in <= 6'h2E;
        repeat (20) @(posedge mclk);
        chk(osc_run, 32'h0);
        pb_in <= 6'h2F;
        wait (paddr === 11'h7FF);
        rdchk(8'h08, 32'h90);
        chk(osc_run, 32'h1);
        repeat (100) @(posedge mclk);
        master_clear_pin_n <= 1'h0;
        repeat (2) @(posedge mclk);
        master_clear_pin_n <= 1'h1;
        rdchk(8'h08, 32'h10);
        repeat (100) @(posedge mclk);
        wait (paddr === 11'h7FF);
        rdchk(8'h08, 32'h00);
        // clearing the run bit must freeze fetch
        wb(1'h1, 8'h00, 32'h6);
        rdchk(8'h00, 32'h6);
        rd = {21'h0, paddr};
        repeat (12) @(posedge mclk);
        chk(paddr, rd);
        finish_test;
    end
endmodule
